// [hdl/adc_seq_pkg.sv]
package adc_seq_pkg;
  // Clock and reset calibration timing
  localparam int CLK_FREQ_MHZ     = 50;         // clk_i rate
  localparam int NS_PER_US        = 1000;
  localparam int RESET_CAL_NS     = 1_600_000;  // Least reset calibration time
  localparam int RESET_CAL_CYCLES = RESET_CAL_NS * CLK_FREQ_MHZ / NS_PER_US;
  localparam int CAL_CNT_W        = 17;         // Holds 80000

  // Conversion clock in base clock periods (one base period is one clk_i)
  localparam logic [7:0] TCC_SEL00 = 8'h18;     // 24
  localparam logic [7:0] TCC_SEL10 = 8'h60;     // 96
  localparam logic [7:0] TCC_SEL11 = 8'h30;     // 48
  localparam logic [1:0] CCS_RESERVED = 2'h1;

  // Phase lengths
  localparam logic [4:0] SAMPLE_TSC_N = 5'h02;  // Sample clock periods
  localparam logic [4:0] CONV_TCC_N   = 5'h0e;  // Conversion clock periods
  localparam logic [4:0] XFER_TCL_N   = 5'h04;  // Base clock periods
  localparam logic [4:0] CAL_TCC_N    = 5'h04;  // Calibration cycle length

  // Widths
  localparam int CH_W   = 4;
  localparam int NUM_CH = 16;
  localparam int RES_W  = 10;
  localparam int ADR_W  = 8;
  localparam int DAT_W  = 32;

  // Register byte offsets
  localparam logic [ADR_W-1:0] ADR_CTRL    = 8'h00;
  localparam logic [ADR_W-1:0] ADR_RESULT  = 8'h04;
  localparam logic [ADR_W-1:0] ADR_INJ     = 8'h08;
  localparam logic [ADR_W-1:0] ADR_STATUS  = 8'h0c;
  localparam logic [ADR_W-1:0] ADR_IRQ_CLR = 8'h10;
  localparam logic [ADR_W-1:0] ADR_IRQ_EN  = 8'h14;
  localparam logic [ADR_W-1:0] ADR_DIGIN   = 8'h18;

  // Field positions
  localparam int CTRL_W        = 18;
  localparam int CTRL_BUSY_BIT = 18;
  localparam int CTRL_CAL_BIT  = 19;
  localparam int RES_CH_LSB    = 12;
  localparam int MODE_CONT_BIT = 0;
  localparam int MODE_SCAN_BIT = 1;

  // Sticky status bits
  localparam int STS_W    = 4;
  localparam int STS_DONE = 0;
  localparam int STS_OVR  = 1;
  localparam int STS_INJ  = 2;
  localparam int STS_XFER = 3;

  // Control register layout, msb first
  typedef struct packed {
    logic [CH_W-1:0] inj_ch;
    logic [1:0]      sample_clock_select;
    logic [1:0]      conv_clock_select;
    logic            inj_req;
    logic            wait_for_read_bit;
    logic            ovr_protect;
    logic            start;
    logic [1:0]      mode;
    logic [CH_W-1:0] ch;
  } ctrl_type;

  // Drive towards the analog multiplexer and conversion core
  typedef struct packed {
    logic [CH_W-1:0] mux_sel;
    logic            sample;
    logic            convert;
    logic            calib;
  } analog_ctrl_type;
endpackage : adc_seq_pkg

// [hdl/adc_conversion_sequencer.sv]
// The address map and the Wishbone slave port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module adc_conversion_sequencer import adc_seq_pkg::*; #(
  parameter int RESET_CAL_CYCLES_P = RESET_CAL_CYCLES  // Shorten for simulation
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [ADR_W-1:0]     wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [DAT_W-1:0]     wb_dat_i,
  output logic      [DAT_W-1:0]     wb_dat_o,
  output logic                      wb_ack_o,
  input  wire logic [RES_W-1:0]     core_result_i,
  input  wire logic [NUM_CH-1:0]    digital_pin_i,
  output var analog_ctrl_type       ana_o,
  output logic                      busy_o,
  output logic                      xfer_req_o,
  output logic                      irq_o
);

  typedef enum logic [2:0] {S_IDLE, S_SAMPLE, S_CONVERT, S_XFER, S_WAIT, S_CAL} state_type;

  state_type             state_q, state_d;      // Sequencer state
  ctrl_type              ctrl_q;                // Converter control
  logic [RES_W-1:0]      result_q;              // Conversion result value
  logic [CH_W-1:0]       result_ch_q;           // Channel of that result
  logic [RES_W-1:0]      inj_result_q;          // Injection result value
  logic [CH_W-1:0]       inj_ch_res_q;          // Channel of injection result
  logic [RES_W-1:0]      temp_q;                // Temporary buffer while held
  logic                  unread_q;              // Result not yet read
  logic [STS_W-1:0]      status_q;              // Sticky events
  logic [STS_W-1:0]      irq_en_q;              // Interrupt enables
  logic [CH_W-1:0]       conv_ch_q;             // Channel being converted
  logic [CH_W-1:0]       next_ch_q;             // Next normal channel
  logic                  is_inj_q;              // Current conversion is injected
  logic                  inj_pend_q;            // Injection waiting to run
  logic [7:0]            cc_div_q;              // Conversion clock divider
  logic [4:0]            tick_cnt_q;            // Ticks within a phase
  logic [CAL_CNT_W-1:0]  cal_cnt_q;             // Reset calibration remaining
  logic [RES_W-1:0]      core_s1_q, core_s2_q;  // Result synchroniser
  logic [NUM_CH-1:0]     pin_s1_q, pin_s2_q;    // Pin synchroniser

  // Bus decode
  logic            wb_req;     // Request seen, not yet answered
  logic            wr_ctrl;    // Control write
  logic            rd_result;  // Result register read
  logic [DAT_W-1:0] wmask;     // Byte lane mask
  logic [DAT_W-1:0] ctrl_wr;   // Merged control write value
  ctrl_type         ctrl_new;  // Decoded control write

  assign wb_req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_ctrl   = wb_req && wb_we_i && (wb_adr_i == ADR_CTRL);
  assign rd_result = wb_req && !wb_we_i && (wb_adr_i == ADR_RESULT);
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[b*8 +: 8] = {8{wb_sel_i[b]}};
    end
  end
  assign ctrl_wr  = (DAT_W'(ctrl_q) & ~wmask) | (wb_dat_i & wmask);
  assign ctrl_new = ctrl_type'(ctrl_wr[CTRL_W-1:0]);

  // Timing derived from the clock selects
  logic [7:0] tcc_len;     // Conversion clock in clk_i cycles
  logic       cc_tick;     // One pulse per conversion clock
  logic       phase_tick;  // Counting event of the current phase
  logic [4:0] phase_len;   // Ticks the current phase lasts
  logic       phase_done;  // Last tick of the phase

  always_comb begin
    unique case (ctrl_q.conv_clock_select)
      2'h2:    tcc_len = TCC_SEL10;
      2'h3:    tcc_len = TCC_SEL11;
      default: tcc_len = TCC_SEL00;  // Reserved code behaves as 00
    endcase
  end
  assign cc_tick    = (cc_div_q == tcc_len - 8'h01);
  assign phase_tick = (state_q == S_XFER) ? 1'b1 : cc_tick;

  // Phase lengths: sample 2 tsc, convert 14 tcc, transfer 4 tcl, cal 4 tcc
  always_comb begin
    unique case (state_q)
      S_SAMPLE:  phase_len = SAMPLE_TSC_N << ctrl_q.sample_clock_select;
      S_CONVERT: phase_len = CONV_TCC_N;
      S_XFER:    phase_len = XFER_TCL_N;
      S_CAL:     phase_len = CAL_TCC_N;
      default:   phase_len = CAL_TCC_N;
    endcase
  end
  assign phase_done = phase_tick && (tick_cnt_q == phase_len - 5'h01);

  // Next normal channel after the one just done
  logic            scan_mode;    // Auto-scan selected
  logic            cont_mode;    // Continuous selected
  logic            run_on;       // Another normal conversion follows
  logic [CH_W-1:0] follow_ch;    // Its channel
  logic            hold_result;  // Result must wait in the buffer
  logic            res_wr;       // Result register written now
  logic            start_ok;     // Start accepted

  assign scan_mode = ctrl_q.mode[MODE_SCAN_BIT];
  assign cont_mode = ctrl_q.mode[MODE_CONT_BIT];
  always_comb begin
    run_on    = cont_mode;
    follow_ch = next_ch_q;
    if (is_inj_q) begin
      run_on = 1'b1;  // Injection resumes the running mode
    end else if (scan_mode) begin
      if (next_ch_q == '0) begin
        run_on    = cont_mode;  // Restart or stop at channel zero
        follow_ch = ctrl_q.ch;
      end else begin
        run_on    = 1'b1;
        follow_ch = next_ch_q - 1'b1;
      end
    end
  end

  // Held when protection is on, or wait-for-read in a continuous mode
  assign hold_result = !is_inj_q && unread_q &&
                       (ctrl_q.ovr_protect || (ctrl_q.wait_for_read_bit && cont_mode));
  assign res_wr   = (!is_inj_q && state_q == S_XFER && phase_done && !hold_result) ||
                    (state_q == S_WAIT && rd_result);
  assign start_ok = wr_ctrl && ctrl_new.start && state_q == S_IDLE;

  // Channel for the multiplexer, taken from where the tracker goes next
  // Without it the first sample cycle would still show the previous channel
  logic [CH_W-1:0] mux_next;  // Channel shown from the next cycle on
  always_comb begin
    mux_next = conv_ch_q;
    if (start_ok) begin
      mux_next = ctrl_new.ch;
    end else if (state_q == S_CAL && phase_done) begin
      if (inj_pend_q && cont_mode) begin
        mux_next = ctrl_q.inj_ch;
      end else if (is_inj_q) begin
        mux_next = next_ch_q;  // Resume the interrupted sequence
      end else begin
        mux_next = follow_ch;
      end
    end
  end

  // Sequencer next state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      S_IDLE:    if (start_ok) state_d = S_SAMPLE;
      S_SAMPLE:  if (phase_done) state_d = S_CONVERT;
      S_CONVERT: if (phase_done) state_d = S_XFER;
      S_XFER:    if (phase_done) state_d = hold_result ? S_WAIT : S_CAL;
      S_WAIT:    if (rd_result) state_d = S_CAL;  // Conversion on hold until read
      S_CAL: begin
        if (phase_done) begin
          state_d = (run_on || (inj_pend_q && cont_mode)) ? S_SAMPLE : S_IDLE;
        end
      end
    endcase
  end

  // State and phase counters; divider restarts on every phase change
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q    <= S_IDLE;
      cc_div_q   <= '0;
      tick_cnt_q <= '0;
    end else begin
      state_q <= state_d;
      if (state_d != state_q || state_q == S_IDLE || state_q == S_WAIT) begin
        cc_div_q   <= '0;
        tick_cnt_q <= '0;
      end else begin
        cc_div_q <= cc_tick ? 8'h00 : cc_div_q + 8'h01;
        if (phase_tick) tick_cnt_q <= tick_cnt_q + 5'h01;
      end
    end
  end

  // Channel tracking and injection
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      conv_ch_q  <= '0;
      next_ch_q  <= '0;
      is_inj_q   <= 1'b0;
      inj_pend_q <= 1'b0;
    end else begin
      if (start_ok) begin
        conv_ch_q <= ctrl_new.ch;
        next_ch_q <= ctrl_new.ch;  // Scan starts from the upper channel
        is_inj_q  <= 1'b0;
      end else if (state_q == S_CAL && phase_done) begin
        if (inj_pend_q && cont_mode) begin
          conv_ch_q  <= ctrl_q.inj_ch;
          is_inj_q   <= 1'b1;
          inj_pend_q <= 1'b0;
          if (!is_inj_q) next_ch_q <= follow_ch;
        end else begin
          conv_ch_q <= is_inj_q ? next_ch_q : follow_ch;
          next_ch_q <= is_inj_q ? next_ch_q : follow_ch;
          is_inj_q  <= 1'b0;
        end
      end
      // One injection accepted only while a continuous mode runs
      if (wr_ctrl && ctrl_new.inj_req && ctrl_q.mode[MODE_CONT_BIT] && state_q != S_IDLE) begin
        inj_pend_q <= 1'b1;
      end else if (state_q == S_IDLE) begin
        inj_pend_q <= 1'b0;
      end
    end
  end

  // Synchronisers for the core result and channel pins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      core_s1_q <= '0;
      core_s2_q <= '0;
      pin_s1_q  <= '0;
      pin_s2_q  <= '0;
    end else begin
      core_s1_q <= core_result_i;
      core_s2_q <= core_s1_q;
      pin_s1_q  <= digital_pin_i;
      pin_s2_q  <= pin_s1_q;
    end
  end

  // Result registers; core output is settled through the transfer phase
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result_q     <= '0;
      result_ch_q  <= '0;
      inj_result_q <= '0;
      inj_ch_res_q <= '0;
      temp_q       <= '0;
    end else begin
      if (state_q == S_XFER && phase_done) begin
        if (is_inj_q) begin
          inj_result_q <= core_s2_q;
          inj_ch_res_q <= conv_ch_q;
        end else if (hold_result) begin
          temp_q <= core_s2_q;  // Temporary buffer
        end else begin
          result_q    <= core_s2_q;
          result_ch_q <= conv_ch_q;
        end
      end else if (state_q == S_WAIT && rd_result) begin
        result_q    <= temp_q;  // Buffered value moves in after the read
        result_ch_q <= conv_ch_q;
      end
    end
  end

  // Unread flag: a new result wins over the read in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      unread_q <= 1'b0;
    end else if (res_wr) begin
      unread_q <= 1'b1;
    end else if (rd_result) begin
      unread_q <= 1'b0;
    end
  end

  // Reset calibration counts only while no conversion runs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cal_cnt_q <= CAL_CNT_W'(RESET_CAL_CYCLES_P);
    end else if (cal_cnt_q != '0 && state_q == S_IDLE) begin
      cal_cnt_q <= cal_cnt_q - 1'b1;  // Conversions stretch it
    end
  end

  // Control register; start and injection bits are commands, never stored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= '0;
    end else if (wr_ctrl) begin
      ctrl_q         <= ctrl_new;
      ctrl_q.start   <= 1'b0;
      ctrl_q.inj_req <= 1'b0;
      // Reserved clock code is refused, previous select kept
      if (ctrl_new.conv_clock_select == CCS_RESERVED) begin
        ctrl_q.conv_clock_select <= ctrl_q.conv_clock_select;
      end
    end
  end

  // Sticky events, set wins over a clear in the same cycle
  logic [STS_W-1:0] sts_set;  // Events this cycle
  always_comb begin
    sts_set           = '0;
    sts_set[STS_DONE] = res_wr;
    sts_set[STS_OVR]  = res_wr && unread_q && !rd_result;
    sts_set[STS_INJ]  = is_inj_q && state_q == S_XFER && phase_done;
    sts_set[STS_XFER] = res_wr && scan_mode;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_q <= '0;
      irq_en_q <= '0;
    end else begin
      if (wb_req && wb_we_i && wb_adr_i == ADR_IRQ_CLR) begin
        status_q <= (status_q & ~wb_dat_i[STS_W-1:0]) | sts_set;
      end else begin
        status_q <= status_q | sts_set;
      end
      if (wb_req && wb_we_i && wb_adr_i == ADR_IRQ_EN) begin
        irq_en_q <= (irq_en_q & ~wmask[STS_W-1:0]) | (wb_dat_i[STS_W-1:0] & wmask[STS_W-1:0]);
      end
    end
  end

  // Channels selected for normal conversion are hidden from the digital view
  logic [NUM_CH-1:0] used_mask;  // Channels taken by conversion
  always_comb begin
    used_mask = '0;
    for (int c = 0; c < NUM_CH; c++) begin
      if (scan_mode ? (c <= int'(ctrl_q.ch)) : (c == int'(ctrl_q.ch))) used_mask[c] = 1'b1;
    end
  end

  // Read multiplexer; unmapped offsets answer zero
  logic [DAT_W-1:0] rd_data;  // Word for the current read
  logic             busy_d;   // Busy view
  assign busy_d = (cal_cnt_q != '0) || (state_q != S_IDLE);
  always_comb begin
    rd_data = '0;
    unique case (wb_adr_i)
      ADR_CTRL: begin
        rd_data[CTRL_W-1:0]  = ctrl_q;
        rd_data[CTRL_BUSY_BIT] = busy_d;
        rd_data[CTRL_CAL_BIT]  = (cal_cnt_q != '0);
      end
      ADR_RESULT: begin
        rd_data[RES_W-1:0]               = result_q;
        rd_data[RES_CH_LSB +: CH_W]      = result_ch_q;
      end
      ADR_INJ: begin
        rd_data[RES_W-1:0]               = inj_result_q;
        rd_data[RES_CH_LSB +: CH_W]      = inj_ch_res_q;
      end
      ADR_STATUS: rd_data[STS_W-1:0]   = status_q;
      ADR_IRQ_EN: rd_data[STS_W-1:0]   = irq_en_q;
      ADR_DIGIN:  rd_data[NUM_CH-1:0]  = pin_s2_q & ~used_mask;
      default:    rd_data = '0;
    endcase
  end

  // Bus answer: ack one cycle after the request, dropped the next
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i) wb_dat_o <= rd_data;
    end
  end

  // Registered outputs towards the core and the system
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ana_o      <= '0;
      busy_o     <= 1'b1;
      xfer_req_o <= 1'b0;
      irq_o      <= 1'b0;
    end else begin
      ana_o.mux_sel <= mux_next;
      ana_o.sample  <= (state_d == S_SAMPLE);
      ana_o.convert <= (state_d == S_CONVERT);
      ana_o.calib   <= (state_d == S_CAL) || (cal_cnt_q != '0 && state_d == S_IDLE);
      busy_o        <= busy_d;
      xfer_req_o    <= sts_set[STS_XFER];
      irq_o         <= |((status_q | sts_set) & irq_en_q);
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_SCAN_STEP: assert property (
    state_q == S_CAL && phase_done && scan_mode && !is_inj_q && !inj_pend_q &&
    next_ch_q != '0 |=> conv_ch_q == $past(next_ch_q) - 1'b1)
    else $error("Scan did not step down one channel");
  AST_OVERRUN: assert property (
    res_wr && unread_q && !rd_result |=> status_q[STS_OVR])
    else $error("Overrun not flagged");
  AST_HOLD: assert property (
    state_q == S_WAIT && !rd_result |=> $stable(result_q) && state_q == S_WAIT || $past(rd_result))
    else $error("Held result overwrote the result register");
  AST_CONV_LEN: assert property (
    $rose(state_q == S_CONVERT) |-> (state_q == S_CONVERT)[*8] ##1 state_q == S_CONVERT)
    else $error("Conversion phase too short");
  AST_CAL_AFTER: assert property (
    state_q == S_XFER && phase_done && !hold_result |=> state_q == S_CAL)
    else $error("No calibration cycle after conversion");
  AST_BUSY_CAL: assert property (
    cal_cnt_q != '0 |=> busy_o)
    else $error("Busy dropped during reset calibration");
  AST_CCS_LEGAL: assert property (
    ctrl_q.conv_clock_select != CCS_RESERVED)
    else $error("Reserved conversion clock select stored");
  AST_SINGLE_STOP: assert property (
    state_q == S_CAL && phase_done && ctrl_q.mode == 2'h0 && !is_inj_q |=> state_q == S_IDLE)
    else $error("Single conversion did not stop");
  AST_XFER_REQ: assert property (
    res_wr && scan_mode |=> xfer_req_o ##1 !xfer_req_o || res_wr)
    else $error("Scan transfer request missing");
  AST_INJ_RESUME: assert property (
    state_q == S_CAL && phase_done && is_inj_q && cont_mode |=> state_q == S_SAMPLE && !is_inj_q)
    else $error("Mode not resumed after injection");

endmodule : adc_conversion_sequencer
`default_nettype wire

// [tb/adc_core_model.sv]
`timescale 1ns/100ps
`default_nettype none
// Conversion core stand-in: value carries the channel for checking
module adc_core_model import adc_seq_pkg::*; (
  input  wire logic            clk_i,
  input  wire analog_ctrl_type ana_i,
  output logic [RES_W-1:0]     result_o
);
  logic [RES_W-1:0] val_q  = 10'h0; // Last converted value
  logic [3:0]       hold_q = 4'h0;  // Cycles of valid output left
  // Track channel while converting, hold over the transfer
  always_ff @(posedge clk_i) begin
    if (ana_i.convert) begin
      val_q  <= {ana_i.mux_sel, 6'h15};
      hold_q <= 4'h8;
    end else if (hold_q != 4'h0) begin
      hold_q <= hold_q - 4'h1;
    end
  end
  // Inverse outside the window, so a late sample cannot match
  assign result_o = (ana_i.convert || hold_q != 4'h0) ? val_q : ~val_q;
endmodule : adc_core_model
`default_nettype wire

// [tb/tb_adc_conversion_sequencer.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_adc_conversion_sequencer import adc_seq_pkg::*; ;
  logic clk_i, rst_i, cyc, stb, we, ack, busy, xreq, irq, smp_q; // Pins
  logic [ADR_W-1:0]  adr;                    // Bus address
  logic [DAT_W-1:0]  wdat, rdat, dat_o;      // Bus data
  logic [3:0]        sel;                    // Byte lanes
  logic [RES_W-1:0]  core_res;               // Core to sequencer
  logic [NUM_CH-1:0] pins;                   // Digital pins
  logic [11:0]       chs;                    // Channels seen at sample
  analog_ctrl_type   ana;                    // Analog drive
  int err_count, n_tests, n_xfer, n_smp, ns, nc, ng, nk, t, s0, tsc;
  typedef struct {logic [3:0] ch; logic [1:0] ccs, scs; int tcc;} row_type;
  // Each sample select code once, conv selects 0, 2 and 3: channel, conv select, sample select, tcc
  row_type rows[4] = '{'{4'h3, 2'h0, 2'h0, 24}, '{4'h7, 2'h2, 2'h1, 96},
                       '{4'hc, 2'h3, 2'h2, 48}, '{4'hf, 2'h0, 2'h3, 24}};
  adc_conversion_sequencer #(.RESET_CAL_CYCLES_P(200)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .core_result_i(core_res), .digital_pin_i(pins),
    .ana_o(ana), .busy_o(busy), .xfer_req_o(xreq), .irq_o(irq));
  adc_core_model u_core (.clk_i(clk_i), .ana_i(ana), .result_o(core_res));
  // Clock, 20 ns period
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // Event counters for sample starts and transfer pulses
  always @(posedge clk_i) begin
    if (ana.sample === 1'b1 && smp_q !== 1'b1) begin
      n_smp <= n_smp + 1;
      chs   <= {chs[7:0], ana.mux_sel};
    end
    if (xreq === 1'b1) n_xfer <= n_xfer + 1;
    smp_q <= ana.sample;
  end
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_tests++;
    if (got !== ex) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  // Classic cycle: hold until ack, take data at that edge
  task automatic wb(input logic w, input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] d);
    int k;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hf;
    k = 0;
    do begin @(posedge clk_i); k++; end while (ack !== 1'b1 && k < 100);
    rdat = dat_o;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    chk("ack", 1, ack);
  endtask : wb
  function automatic logic [DAT_W-1:0] cw(logic [3:0] ch, logic [1:0] md, logic st,
                                          logic inj, logic [1:0] cc, logic [1:0] sc,
                                          logic [3:0] ich);
    ctrl_type c;
    c = '{ich, sc, cc, inj, 1'b0, 1'b0, st, md, ch};
    return {14'h0, c};
  endfunction : cw
  // Bounded wait for the sequencer to go idle
  task automatic wait_idle();
    int k;
    k = 0;
    do begin @(posedge clk_i); k++; end while (busy !== 1'b0 && k < 20000);
    chk("idle", 0, busy);
  endtask : wait_idle
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict
  // Watchdog, far beyond the expected run of some 10500 cycles
  initial begin
    #1_000_000;
    err_count++;
    print_verdict();
  end
  initial begin
    rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = '0; wdat = '0;
    sel = 4'h0; pins = 16'hffff; err_count = 0; n_tests = 0; n_xfer = 0;
    n_smp = 0; chs = '0; smp_q = 1'b0;
    repeat (8) @(posedge clk_i);
    chk("busy_rst", 1, busy);
    chk("ana_rst", 0, ana);
    rst_i <= 1'b0;
    repeat (150) @(posedge clk_i);
    chk("busy_cal", 1, busy);
    wait_idle();
    $display("test reset done");
    wb(1'b1, ADR_IRQ_EN, 32'h2);
    // Single conversions, phase lengths measured at the pins
    foreach (rows[i]) begin
      tsc = rows[i].tcc << rows[i].scs;
      wb(1'b1, ADR_CTRL, cw(rows[i].ch, 2'h0, 1'b1, 1'b0, rows[i].ccs, rows[i].scs, 4'h0));
      t = 0;
      while (ana.sample !== 1'b1 && t < 5000) begin @(posedge clk_i); t++; end
      ns = 0; nc = 0; ng = 0; nk = 0;
      while (ana.sample === 1'b1) begin ns++; @(posedge clk_i); end
      while (ana.convert === 1'b1) begin nc++; @(posedge clk_i); end
      while (ana.calib !== 1'b1 && ng < 50) begin ng++; @(posedge clk_i); end
      while (ana.calib === 1'b1) begin nk++; @(posedge clk_i); end
      chk("sample_len", 2 * tsc, ns);
      chk("convert_len", 14 * rows[i].tcc, nc);
      chk("xfer_len", 4, ng);
      chk("calib_len", 4 * rows[i].tcc, nk);
      chk("mux", rows[i].ch, chs[3:0]);
      wait_idle();
      wb(1'b0, ADR_RESULT, 0);
      chk("result", {16'h0, rows[i].ch, 2'h0, rows[i].ch, 6'h15}, rdat);
      wb(1'b0, ADR_DIGIN, 0);
      chk("digin", ~(32'h1 << rows[i].ch) & 32'hffff, rdat);
    end
    $display("test single rows done");
    // Reserved select refused, unmapped place reads zero
    wb(1'b1, ADR_CTRL, cw(4'h0, 2'h0, 1'b0, 1'b0, 2'h3, 2'h0, 4'h0));
    wb(1'b1, ADR_CTRL, cw(4'h0, 2'h0, 1'b0, 1'b0, 2'h1, 2'h0, 4'h0));
    wb(1'b0, ADR_CTRL, 0);
    chk("ccs_rsv", 2'h3, rdat[11:10]);
    wb(1'b0, 8'h40, 0);
    chk("unmapped", 0, rdat);
    $display("test reserved done");
    // Continuous run with one injected channel
    s0 = n_smp;
    wb(1'b1, ADR_CTRL, cw(4'h4, 2'h1, 1'b1, 1'b0, 2'h0, 2'h0, 4'h0));
    repeat (1200) @(posedge clk_i);
    wb(1'b1, ADR_CTRL, cw(4'h4, 2'h1, 1'b0, 1'b1, 2'h0, 2'h0, 4'h9));
    t = 0;
    do begin wb(1'b0, ADR_STATUS, 0); t++; end while (rdat[STS_INJ] !== 1'b1 && t < 500);
    wb(1'b0, ADR_INJ, 0);
    chk("inj_result", {16'h0, 4'h9, 2'h0, 4'h9, 6'h15}, rdat);
    wb(1'b0, ADR_RESULT, 0);
    chk("cont_result", {16'h0, 4'h4, 2'h0, 4'h4, 6'h15}, rdat);
    wb(1'b1, ADR_CTRL, cw(4'h4, 2'h0, 1'b0, 1'b0, 2'h0, 2'h0, 4'h0));
    wait_idle();
    chk("cont_repeat", 1, (n_smp - s0) >= 4);
    $display("test injection done");
    // Scan down from channel 2, results left unread
    wb(1'b1, ADR_IRQ_CLR, 32'hf);
    s0 = n_xfer;
    wb(1'b1, ADR_CTRL, cw(4'h2, 2'h2, 1'b1, 1'b0, 2'h0, 2'h0, 4'h0));
    wait_idle();
    chk("xfer_count", 3, n_xfer - s0);
    chk("scan_order", 12'h210, chs);
    chk("irq_ovr", 1, irq);
    wb(1'b0, ADR_STATUS, 0);
    chk("sts_ovr", 1, rdat[STS_OVR]);
    wb(1'b1, ADR_IRQ_CLR, 32'h2);
    repeat (2) @(posedge clk_i);
    chk("irq_clr", 0, irq);
    $display("test scan done");
    // Overrun protection: scan result still unread, so the run holds
    wb(1'b1, ADR_IRQ_CLR, 32'hf);
    wb(1'b1, ADR_CTRL, cw(4'h5, 2'h1, 1'b1, 1'b0, 2'h0, 2'h0, 4'h0) | 32'h80);
    repeat (1500) @(posedge clk_i);
    chk("hold_busy", 1, busy);
    wb(1'b0, ADR_STATUS, 0);
    chk("hold_no_ovr", 0, rdat[STS_OVR]);
    wb(1'b1, ADR_CTRL, cw(4'h5, 2'h0, 1'b0, 1'b0, 2'h0, 2'h0, 4'h0) | 32'h80);
    wb(1'b0, ADR_RESULT, 0);
    chk("hold_old", {16'h0, 4'h0, 2'h0, 4'h0, 6'h15}, rdat);
    wait_idle();
    wb(1'b0, ADR_RESULT, 0);
    chk("held_result", {16'h0, 4'h5, 2'h0, 4'h5, 6'h15}, rdat);
    $display("test protect done");
    print_verdict();
  end
endmodule : tb_adc_conversion_sequencer
`default_nettype wire
